// ---- logic/smld_datapath.sv ----
// Signed multiply-accumulate datapath: dual 32-bit accumulate, long
// 32x32, halfword long and dual long accumulate, one cycle per issue.
// Assumes decode supplies legal register numbers and operand values.
//
// Function
// - Dual accumulate writes the low 32 bits of both products plus acc.
// - Dual accumulate sets the sticky saturation flag on overflow only.
// - Swap set rotates the second operand by 16 before the products.
// - Long 32x32 multiplies signed words and adds the 64-bit pair.
// - Long variants take hi/lo as accumulator and write 63:32 and 31:0.
// - Long 32x32 never touches any condition flag.
// - Halfword variant uses one signed half of each source.
// - Selector one picks the top half of the matching source.
// - Halfword product is sign-extended to 64 bits before adding.
// - Long 64-bit sums wrap with no overflow detection.
// - Dual long adds two signed 16x16 products to the 64-bit pair.
// - Dual long pairs bits 15:0 and bits 31:16 of both operands.
// - Swap clear pairs bottom with bottom and top with top.
`timescale 1ns/1ns
`include "smld_regs.svh"
module smld_datapath
   import smld_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic issue_i,
   input wire logic cond_pass_i,
   input wire smld_op_t op_i,
   input wire logic first_high_i,
   input wire logic second_high_i,
   input wire logic swap_i,
   input wire logic [3:0] dest_lo_num_i,
   input wire logic [3:0] dest_hi_num_i,
   input wire logic [31:0] first_operand_reg_i,
   input wire logic [31:0] second_operand_reg_i,
   input wire logic [31:0] accumulate_reg_i,
   input wire logic [31:0] acc_hi_i,
   input wire logic [31:0] acc_lo_i,
   input wire logic sat_clear_i,
   output logic [31:0] result_lo_o,
   output logic [31:0] result_hi_o,
   output logic wr_lo_o,
   output logic wr_hi_o,
   output logic sticky_saturation_flag_o,
   output logic illegal_use_o
);

   function automatic logic signed [31:0] smul16(
      input logic [15:0] a,
      input logic [15:0] b);
      smul16 = $signed(a) * $signed(b);
   endfunction

   function automatic logic bad_reg(input logic [3:0] r);
      bad_reg = (r == `SMLD_DREG_SP) || (r == `SMLD_DREG_PC);
   endfunction

   wire logic take = issue_i && cond_pass_i;
   wire logic is_dual = op_i == SMLD_OP_DUAL_MAC;
   wire logic is_long = !is_dual;
   // Rotation by half a word, so halves trade places
   wire logic [31:0] op2_rot = swap_i ?
      {second_operand_reg_i[15:0], second_operand_reg_i[31:16]} :
      second_operand_reg_i;
   wire logic signed [31:0] prod_bot =
      smul16(first_operand_reg_i[15:0], op2_rot[15:0]);
   wire logic signed [31:0] prod_top =
      smul16(first_operand_reg_i[31:16], op2_rot[31:16]);
   wire logic [15:0] half_a = first_high_i ?
      first_operand_reg_i[31:16] : first_operand_reg_i[15:0];
   wire logic [15:0] half_b = second_high_i ?
      second_operand_reg_i[31:16] : second_operand_reg_i[15:0];
   wire logic signed [31:0] prod_half = smul16(half_a, half_b);
   wire logic signed [63:0] prod_word =
      $signed(first_operand_reg_i) * $signed(second_operand_reg_i);
   wire logic [63:0] acc64 = {acc_hi_i, acc_lo_i};
   // Dual sum kept at 34 bits so overflow is exact
   wire logic signed [33:0] dual_sum = 34'(prod_bot) + 34'(prod_top)
      + 34'($signed(accumulate_reg_i));
   wire logic dual_ovf =
      dual_sum != 34'($signed(dual_sum[31:0]));
   wire logic [63:0] prod_sel =
      (op_i == SMLD_OP_LONG_MAC_32X32) ? prod_word :
      (op_i == SMLD_OP_LONG_MAC_HALF) ? 64'(prod_half) :
      64'(prod_bot) + 64'(prod_top);
   wire logic [63:0] long_sum = prod_sel + acc64;
   wire logic bad_long = is_long && (bad_reg(dest_lo_num_i) ||
      bad_reg(dest_hi_num_i) || dest_lo_num_i == dest_hi_num_i);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         result_lo_o <= 32'h0;
         result_hi_o <= 32'h0;
         wr_lo_o <= 1'b0;
         wr_hi_o <= 1'b0;
         illegal_use_o <= 1'b0;
      end else begin
         wr_lo_o <= take;
         wr_hi_o <= take && is_long;
         illegal_use_o <= issue_i && bad_long;
         if (take) begin
            result_lo_o <= is_dual ? dual_sum[31:0] : long_sum[31:0];
            result_hi_o <= is_dual ? result_hi_o : long_sum[63:32];
         end
      end
   end

   // Set beats a same-cycle clear; long ops never alter it
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sticky_saturation_flag_o <= 1'b0;
      end else if (take && is_dual && dual_ovf) begin
         sticky_saturation_flag_o <= 1'b1;
      end else if (sat_clear_i) begin
         sticky_saturation_flag_o <= 1'b0;
      end
   end

   dual_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      take && is_dual |=> result_lo_o == $past(dual_sum[31:0]))
      else $error("dual result wrong");
   sat_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      take && is_dual && dual_ovf |=> sticky_saturation_flag_o)
      else $error("saturation not set");
   long_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      take && is_long && !sat_clear_i |=> $stable(sticky_saturation_flag_o))
      else $error("long op changed flag");
   long_pair_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      take && is_long |=> {result_hi_o, result_lo_o} == $past(long_sum))
      else $error("long result wrong");
   word_mac_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      take && op_i == SMLD_OP_LONG_MAC_32X32 |=> {result_hi_o, result_lo_o}
      == $past(64'(prod_word) + acc64))
      else $error("32x32 mac wrong");
   half_ext_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      take && op_i == SMLD_OP_LONG_MAC_HALF |=> {result_hi_o, result_lo_o}
      == $past(64'(prod_half) + acc64))
      else $error("half mac wrong");
   swap_pair_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      swap_i |-> op2_rot[15:0] == second_operand_reg_i[31:16])
      else $error("swap pairing wrong");
   cond_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      issue_i && !cond_pass_i |=> !wr_lo_o && !wr_hi_o
      && $stable(result_lo_o) && $stable(result_hi_o))
      else $error("failed condition wrote");

   // Write pulses follow a taken issue by exactly one edge
   sequence long_take_s;
      take && is_long;
   endsequence

   sequence pair_write_s;
      ##1 wr_lo_o && wr_hi_o;
   endsequence

   sequence dual_take_s;
      take && is_dual;
   endsequence

   sequence low_write_s;
      ##1 wr_lo_o && !wr_hi_o;
   endsequence

   long_write_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      long_take_s |-> pair_write_s)
      else $error("long write pulse missing");
   dual_write_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      dual_take_s |-> low_write_s)
      else $error("dual write pulse wrong");
   idle_write_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !take |=> !wr_lo_o && !wr_hi_o)
      else $error("write without taken issue");
   dual_hold_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      dual_take_s |=> $stable(result_hi_o))
      else $error("dual op touched high word");

   // Flag only moves on a dual overflow or a clear
   flag_keep_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !(take && is_dual && dual_ovf) && !sat_clear_i
      |=> $stable(sticky_saturation_flag_o))
      else $error("flag moved without cause");
   flag_clear_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      sat_clear_i && !(take && is_dual && dual_ovf)
      |=> !sticky_saturation_flag_o)
      else $error("flag clear ignored");

   // Dual long: both halfword products land in the pair
   dual_long_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      take && op_i == SMLD_OP_DUAL_LONG_MAC |=> {result_hi_o, result_lo_o}
      == $past(64'(prod_bot) + 64'(prod_top) + acc64))
      else $error("dual long mac wrong");
   // Swap clear must leave the second operand in place
   no_swap_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !swap_i |-> op2_rot == second_operand_reg_i)
      else $error("unswapped pairing wrong");

   // Halfword picks checked straight from the sources, not the muxes
   half_bot_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      take && op_i == SMLD_OP_LONG_MAC_HALF && !first_high_i
      && !second_high_i |=> {result_hi_o, result_lo_o} == $past(64'(smul16(
      first_operand_reg_i[15:0], second_operand_reg_i[15:0])) + acc64))
      else $error("bottom halves wrong");
   half_top_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      take && op_i == SMLD_OP_LONG_MAC_HALF && first_high_i
      && second_high_i |=> {result_hi_o, result_lo_o} == $past(64'(smul16(
      first_operand_reg_i[31:16], second_operand_reg_i[31:16])) + acc64))
      else $error("top halves wrong");

   // Diagnostic only; the write still goes ahead
   illegal_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      issue_i && bad_long |=> illegal_use_o)
      else $error("illegal use not flagged");
   legal_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !(issue_i && bad_long) |=> !illegal_use_o)
      else $error("legal use flagged");
endmodule

// ---- logic/smld_regs.svh ----
// Constants for the signed multiply-accumulate datapath.
// Assumes inclusion by the package and the datapath module only.
`ifndef SMLD_REGS_SVH
`define SMLD_REGS_SVH
`define SMLD_HALF_W 16
`define SMLD_WORD_W 32
`define SMLD_LONG_W 64
`define SMLD_ROT_AMT 16
`define SMLD_DREG_SP 4'hD
`define SMLD_DREG_PC 4'hF
`endif

// ---- logic/smld_pkg.sv ----
// Types for the signed multiply-accumulate datapath.
// Assumes the constants header sits beside it.
`include "smld_regs.svh"
package smld_pkg;
   typedef enum logic [2:0] {
      SMLD_OP_DUAL_MAC,
      SMLD_OP_LONG_MAC_32X32,
      SMLD_OP_LONG_MAC_HALF,
      SMLD_OP_DUAL_LONG_MAC
   } smld_op_t;
endpackage

// ---- tb/smld_regfile.sv ----
// Register pair model standing in for the register file.
// Assumes one-cycle write pulses from the datapath.
`timescale 1ns/1ns
module smld_regfile (
   input wire logic ref_clk_i,
   input wire logic ld_i,
   input wire logic [63:0] ld_val_i,
   input wire logic wr_hi_i,
   input wire logic [31:0] res_hi_i,
   input wire logic [31:0] res_lo_i,
   output logic [63:0] pair_o
);
   always @(posedge ref_clk_i) begin
      if (ld_i) pair_o <= ld_val_i;
      if (wr_hi_i) pair_o <= {res_hi_i, res_lo_i};
   end
endmodule

// ---- tb/test_signed_mac_long_datapath.sv ----
// Self-checking bench for the multiply-accumulate datapath.
// Assumes the register pair model drives the long accumulator.
`timescale 1ns/1ns
module test_signed_mac_long_datapath;
   import smld_pkg::*;
   logic clk = 0, rst_n = 0, iss = 0, cp = 0, ld = 0, clr = 0;
   logic [2:0] sel = 0;
   smld_op_t op = SMLD_OP_DUAL_MAC;
   logic [31:0] a = 0, b = 0, c = 0, d, rlo, rhi;
   logic [63:0] ldv = 0, pair;
   logic [3:0] dlo = 4'h1, dhi = 4'h2;
   logic ill;
   logic signed [63:0] e;
   logic [1:0] wrs;
   logic wlo, whi, flag;
   int err_count = 0, comparisons = 0;
   always #10 clk = ~clk;
   smld_regfile i_smld_regfile (.ref_clk_i(clk), .ld_i(ld), .ld_val_i(ldv),
      .wr_hi_i(whi), .res_hi_i(rhi), .res_lo_i(rlo), .pair_o(pair));
   smld_datapath i_smld_datapath (.ref_clk_i(clk), .rst_n_i(rst_n),
      .issue_i(iss), .cond_pass_i(cp), .op_i(op), .first_high_i(sel[2]),
      .second_high_i(sel[1]), .swap_i(sel[0]), .dest_lo_num_i(dlo),
      .dest_hi_num_i(dhi), .first_operand_reg_i(a),
      .second_operand_reg_i(b), .accumulate_reg_i(c), .acc_hi_i(pair[63:32]),
      .acc_lo_i(pair[31:0]), .sat_clear_i(clr), .result_lo_o(rlo),
      .result_hi_o(rhi), .wr_lo_o(wlo), .wr_hi_o(whi),
      .sticky_saturation_flag_o(flag), .illegal_use_o(ill));
   task automatic chk(string n, logic [63:0] x, logic [63:0] g);
      comparisons++;
      if (x !== g) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   // Pair is loaded a cycle ahead so the take sees it settled
   task automatic run(smld_op_t o, logic [2:0] s, logic p, logic [63:0] v);
      @(negedge clk);
      ld = 1;
      ldv = v;
      @(negedge clk);
      ld = 0;
      op = o;
      sel = s;
      cp = p;
      iss = 1;
      @(negedge clk);
      iss = 0;
      wrs = {whi, wlo};
   endtask
   task automatic t_long;
      {a, b} = {32'hFFFFFFFE, 32'h7FFFFFFF};
      e = $signed(a) * $signed(b) + $signed(64'hFFFFFFFF_00000005);
      run(SMLD_OP_LONG_MAC_32X32, 3'h0, 1, 64'hFFFFFFFF_00000005);
      chk("long", e, {rhi, rlo});
      chk("long wr", 2'h3, wrs);
      chk("long flag", 0, flag);
      @(negedge clk);
      chk("pair", e, pair);
      $display("long done");
   endtask
   task automatic t_half;
      {a, b} = {32'h80010003, 32'hFFFE0005};
      for (int i = 0; i < 4; i++) begin
         e = $signed(i[1] ? a[31:16] : a[15:0])
            * $signed(i[0] ? b[31:16] : b[15:0]);
         e = e + 64'h7FFFFFFF_FFFFFFFF;
         run(SMLD_OP_LONG_MAC_HALF, {i[1:0], 1'b0}, 1, 64'h7FFFFFFF_FFFFFFFF);
         chk("half", e, {rhi, rlo});
      end
      $display("half done");
   endtask
   task automatic t_dual_long;
      {a, b} = {32'h8001FFFD, 32'h00077FFF};
      for (int s = 0; s < 2; s++) begin
         d = s ? {b[15:0], b[31:16]} : b;
         e = $signed(a[15:0]) * $signed(d[15:0]);
         e = e + $signed(a[31:16]) * $signed(d[31:16]);
         e = e + 64'hFFFFFFFF_FFFFFFF0;
         run(SMLD_OP_DUAL_LONG_MAC, s[2:0], 1, 64'hFFFFFFFF_FFFFFFF0);
         chk("dual long", e, {rhi, rlo});
      end
      $display("dual long done");
   endtask
   task automatic t_dual;
      {a, b} = {32'h00040004, 32'h00040004};
      for (int k = 0; k < 2; k++) begin
         c = k ? 32'h7FFFFFF0 : 32'h00000010;
         run(SMLD_OP_DUAL_MAC, 3'h0, 1, 0);
         chk("dual", c + 32'h20, rlo);
         chk("sat", k, flag);
         chk("dual wr", 2'h1, wrs);
      end
      run(SMLD_OP_DUAL_MAC, 3'h0, 0, 0);
      chk("refused", 64'h80000010, {wrs, rlo});
      chk("sat kept", 1, flag);
      // Clear held across an overflowing issue: the set must win
      clr = 1;
      run(SMLD_OP_DUAL_MAC, 3'h0, 1, 0);
      chk("set wins", 1, flag);
      clr = 1;
      @(negedge clk);
      clr = 0;
      chk("sat clear", 0, flag);
      $display("dual done");
   endtask
   task automatic t_illegal;
      dhi = 4'h1;
      run(SMLD_OP_LONG_MAC_32X32, 3'h0, 1, 0);
      chk("same dest", 1, ill);
      dhi = 4'hD;
      run(SMLD_OP_LONG_MAC_32X32, 3'h0, 1, 0);
      chk("dest 13", 1, ill);
      dhi = 4'h2;
      run(SMLD_OP_LONG_MAC_32X32, 3'h0, 1, 0);
      chk("legal dest", 0, ill);
      $display("illegal done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      err_count++;
      tally_and_finish;
   end
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1;
      t_long;
      t_half;
      t_dual_long;
      t_dual;
      t_illegal;
      tally_and_finish;
   end
endmodule
